// [rtl/acju_top.sv]
// accumulator datapath with compare and conditional jump, AXI4-Lite slave
`timescale 1ns/1ns
// What this block does
// - Input read of port 255 on bank 0 returns all digital inputs as bits, and loads them into the accumulator only in standalone mode.
// - Reading one digital input on bank 0 returns just 0 or 1.
// - Code 19 applies the typed operation to accumulator and operand, result to accumulator.
// - Types 0 to 4 add, subtract, multiply, divide and take the remainder.
// - Types 5 to 9 do and, or, xor, invert and load the operand.
// - In direct mode the arithmetic command replies status 100 echoing the operand.
// - Code 20 compares accumulator with operand and sets the flags for later jumps.
// - Code 21 in standalone mode loads the program counter when its condition holds, else runs on.
// - Jump types 4 to 7 are greater, greater-equal, lower and lower-equal.
// - Jump types 8 to 11 test timeout, alarm, deviation and position errors.
// - A direct-mode input read leaves the accumulator, standalone mode loads it.
// - Timeout flag sets on a wait timeout and clears on a clear-error command.
module acju_top
  import acju_pkg::*;
#(
  parameter int unsigned N_IN = 8
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [5:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic      [1:0]      s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [5:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic      [31:0]     s_axi_rdata,
  output logic      [1:0]      s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [N_IN-1:0] digital_in,
  input  wire logic            wait_timeout_evt,
  input  wire logic            external_alarm_in,
  input  wire logic            deviation_error_in,
  input  wire logic            position_error_in
);

  logic        aw_full;
  logic        w_full;
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] cmd_word;
  logic [31:0] value_reg;
  logic [7:0]  csum_in;
  logic        standalone;
  logic        go_req;
  logic        clear_err;
  logic [31:0] accumulator;
  logic [31:0] prog_counter;
  logic        flag_zero;
  logic        flag_equal;
  logic        flag_greater;
  logic        flag_lower;
  logic        timeout_error_flag;
  logic [7:0]  reply_status;
  logic [7:0]  reply_tgt;
  logic [7:0]  reply_instr;
  logic [31:0] reply_value;
  logic [7:0]  reply_csum;
  logic [7:0]  cmd_csum;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic        div_mod;
  acju_state_e state;

  wire  [7:0]  instr = cmd_word[7:0];
  wire  [7:0]  typ   = cmd_word[15:8];
  wire  [7:0]  bank  = cmd_word[23:16];
  wire  [7:0]  tgt   = cmd_word[31:24];
  wire         busy  = (state != EX_IDLE);

  // ----------------------------------------------------------------
  // write channel, address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
  assign wr_fire       = aw_full & w_full & ~s_axi_bvalid;
  assign wr_ok         = (aw_addr == REG_CMD) || (aw_addr == REG_VALUE) ||
                         (aw_addr == REG_CSUM) || (aw_addr == REG_CTRL);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command registers; held steady while a division runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_word   <= '0;
      value_reg  <= '0;
      csum_in    <= '0;
      standalone <= 1'b0;
    end else if (wr_fire && !busy) begin
      if (aw_addr == REG_CMD) cmd_word <= merge(cmd_word, w_data, w_strb);
      if (aw_addr == REG_VALUE) value_reg <= merge(value_reg, w_data, w_strb);
      if (aw_addr == REG_CSUM && w_strb[0]) csum_in <= w_data[7:0];
      if (aw_addr == REG_CTRL && w_strb[0]) standalone <= w_data[CTRL_ALONE_BIT];
    end
  end

  assign clear_err = wr_fire & (aw_addr == REG_CTRL) & w_strb[0] & w_data[CTRL_CLEAR_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) go_req <= 1'b0;
    else go_req <= wr_fire & !busy & (aw_addr == REG_CTRL) & w_strb[0] & w_data[CTRL_GO_BIT];
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // checksum over received frame
  acju_csum u_cmd_csum (
    .frame ({tgt, instr, typ, bank, value_reg}),
    .sum   (cmd_csum)
  );

  logic [31:0] alu_out;
  logic [63:0] product;
  logic        cond_true;
  logic [7:0]  next_status;
  logic [31:0] next_reply;
  logic        acc_load;
  logic [31:0] next_acc;
  logic        cmp_en;
  logic        div_start;
  logic        jump_en;

  assign product = accumulator * value_reg;

  always_comb begin
    unique case (typ)
      ACCUMULATOR_OP_CMD_ADD:  alu_out = accumulator + value_reg;
      ACCUMULATOR_OP_CMD_SUB:  alu_out = accumulator - value_reg;
      ACCUMULATOR_OP_CMD_MUL:  alu_out = product[31:0];
      ACCUMULATOR_OP_CMD_AND:  alu_out = accumulator & value_reg;
      ACCUMULATOR_OP_CMD_OR:   alu_out = accumulator | value_reg;
      ACCUMULATOR_OP_CMD_XOR:  alu_out = accumulator ^ value_reg;
      ACCUMULATOR_OP_CMD_NOT:  alu_out = ~accumulator;
      ACCUMULATOR_OP_CMD_LOAD: alu_out = value_reg;
      default:   alu_out = accumulator;
    endcase
  end

  always_comb begin
    unique case (typ)
      8'h00:   cond_true = flag_zero;
      8'h01:   cond_true = ~flag_zero;
      8'h02:   cond_true = flag_equal;
      8'h03:   cond_true = ~flag_equal;
      8'h04:   cond_true = flag_greater;
      8'h05:   cond_true = flag_greater | flag_equal;
      8'h06:   cond_true = flag_lower;
      8'h07:   cond_true = flag_lower | flag_equal;
      8'h08:   cond_true = timeout_error_flag;
      8'h09:   cond_true = external_alarm_in;
      8'h0A:   cond_true = deviation_error_in;
      8'h0B:   cond_true = position_error_in;
      default: cond_true = 1'b0;
    endcase
  end

  always_comb begin
    next_status = ST_OK;
    next_reply  = 32'h0000_0000;
    acc_load    = 1'b0;
    next_acc    = alu_out;
    cmp_en      = 1'b0;
    div_start   = 1'b0;
    jump_en     = 1'b0;
    if (cmd_csum != csum_in) begin
      next_status = ST_BAD_CSUM;
    end else begin
      unique case (instr)
        OP_READ_INPUT: begin
          if (bank != BANK_DIGITAL) begin
            next_status = ST_BAD_VAL;
          end else if (typ == PORT_ALL) begin
            // all inputs as a bit vector
            next_reply = 32'(digital_in);
          end else if (32'(typ) < N_IN) begin
            // single input reads 0 or 1
            next_reply = {31'h0000_0000, digital_in[typ[$clog2(N_IN)-1:0]]};
          end else begin
            next_status = ST_BAD_VAL;
          end
          acc_load = (next_status == ST_OK) && standalone;
          next_acc = next_reply;
        end
        OP_ACC: begin
          next_reply = value_reg;
          if (typ > ACCUMULATOR_OP_CMD_LOAD) begin
            next_status = ST_BAD_TYPE;
          end else if (typ == ACCUMULATOR_OP_CMD_DIV || typ == ACCUMULATOR_OP_CMD_MOD) begin
            // divide by zero leaves accumulator as it was
            if (value_reg == 32'h0000_0000) next_status = ST_BAD_VAL;
            else div_start = 1'b1;
          end else begin
            acc_load = 1'b1;
          end
        end
        OP_COMPARE: cmp_en = 1'b1;
        OP_JUMP: begin
          if (typ > COND_LAST) next_status = ST_BAD_TYPE;
          else jump_en = cond_true;
        end
        default: next_status = ST_BAD_CMD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // divider for types 3 and 4
  // ----------------------------------------------------------------
  acju_div #(
    .W (32)
  ) u_div (
    .clock     (clock),
    .rst       (rst),
    .start     (go_req & div_start),
    .dividend  (accumulator),
    .divisor   (value_reg),
    .done      (div_done),
    .quotient  (div_quot),
    .remainder (div_rem)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state   <= EX_IDLE;
      div_mod <= 1'b0;
    end else begin
      unique case (state)
        EX_IDLE: begin
          if (go_req && div_start) begin
            state   <= EX_DIVIDE;
            div_mod <= (typ == ACCUMULATOR_OP_CMD_MOD);
          end
        end
        EX_DIVIDE: begin
          if (div_done) state <= EX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // accumulator, flags, program counter, reply
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accumulator <= ACC_RST;
    end else if (state == EX_DIVIDE && div_done) begin
      accumulator <= div_mod ? div_rem : div_quot;
    end else if (go_req && acc_load) begin
      accumulator <= next_acc;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_zero    <= 1'b0;
      flag_equal   <= 1'b0;
      flag_greater <= 1'b0;
      flag_lower   <= 1'b0;
    end else if (go_req && cmp_en) begin
      flag_zero    <= (accumulator - value_reg) == 32'h0000_0000;
      flag_equal   <= accumulator == value_reg;
      flag_greater <= $signed(accumulator) > $signed(value_reg);
      flag_lower   <= $signed(accumulator) < $signed(value_reg);
    end
  end

  // timeout flag, set wins over clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) timeout_error_flag <= 1'b0;
    else if (wait_timeout_evt) timeout_error_flag <= 1'b1;
    else if (clear_err) timeout_error_flag <= 1'b0;
  end

  // program counter only moves while running a stored program
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_counter <= PC_RST;
    end else if (go_req && standalone && next_status == ST_OK) begin
      if (jump_en) prog_counter <= value_reg;
      else prog_counter <= prog_counter + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reply_status <= '0;
      reply_tgt    <= '0;
      reply_instr  <= '0;
      reply_value  <= '0;
    end else if (go_req) begin
      reply_status <= next_status;
      reply_tgt    <= tgt;
      reply_instr  <= instr;
      reply_value  <= next_reply;
    end
  end

  acju_csum u_reply_csum (
    .frame ({HOST_ADDR, reply_tgt, reply_status, reply_instr, reply_value}),
    .sum   (reply_csum)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case ({s_axi_araddr[5:2], 2'b00})
        REG_CMD:    s_axi_rdata <= cmd_word;
        REG_VALUE:  s_axi_rdata <= value_reg;
        REG_CSUM:   s_axi_rdata <= {24'h00_0000, csum_in};
        REG_CTRL:   s_axi_rdata <= {30'h0000_0000, standalone, 1'b0};
        REG_STATUS: s_axi_rdata <= {23'h00_0000, position_error_in, deviation_error_in,
                                    external_alarm_in, timeout_error_flag, flag_lower,
                                    flag_greater, flag_equal, flag_zero, busy};
        REG_ACC:    s_axi_rdata <= accumulator;
        REG_REPLY:  s_axi_rdata <= {16'h0000, reply_csum, reply_status};
        REG_RVALUE: s_axi_rdata <= reply_value;
        REG_PC:     s_axi_rdata <= prog_counter;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : acju_top

// [rtl/acju_pkg.sv]
// shared constants of the accumulator, compare and jump unit
package acju_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 6;
  localparam logic [5:0]  REG_CMD    = 6'h00;
  localparam logic [5:0]  REG_VALUE  = 6'h04;
  localparam logic [5:0]  REG_CSUM   = 6'h08;
  localparam logic [5:0]  REG_CTRL   = 6'h0C;
  localparam logic [5:0]  REG_STATUS = 6'h10;
  localparam logic [5:0]  REG_ACC    = 6'h14;
  localparam logic [5:0]  REG_REPLY  = 6'h18;
  localparam logic [5:0]  REG_RVALUE = 6'h1C;
  localparam logic [5:0]  REG_PC     = 6'h20;

  // control and status bit positions
  localparam int unsigned CTRL_GO_BIT    = 0;
  localparam int unsigned CTRL_ALONE_BIT = 1;
  localparam int unsigned CTRL_CLEAR_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT  = 0;

  // ----------------------------------------------------------------
  // command codes and field values
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_INPUT = 8'h0F;
  localparam logic [7:0] OP_ACC        = 8'h13;
  localparam logic [7:0] OP_COMPARE    = 8'h14;
  localparam logic [7:0] OP_JUMP       = 8'h15;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_ADD      = 8'h00;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_SUB      = 8'h01;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_MUL      = 8'h02;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_DIV      = 8'h03;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_MOD      = 8'h04;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_AND      = 8'h05;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_OR       = 8'h06;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_XOR      = 8'h07;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_NOT      = 8'h08;
  localparam logic [7:0] ACCUMULATOR_OP_CMD_LOAD     = 8'h09;
  localparam logic [7:0] COND_LAST     = 8'h0B;
  localparam logic [7:0] PORT_ALL      = 8'hFF;
  localparam logic [7:0] BANK_DIGITAL  = 8'h00;

  // reply status codes
  localparam logic [7:0] ST_OK       = 8'h64;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD  = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VAL  = 8'h04;

  // reset values and bus answers
  localparam logic [31:0] ACC_RST     = 32'h0000_0000;
  localparam logic [31:0] PC_RST      = 32'h0000_0000;
  localparam logic [7:0]  HOST_ADDR   = 8'h02;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {EX_IDLE, EX_DIVIDE} acju_state_e;

endpackage : acju_pkg

// [rtl/acju_csum.sv]
// modulo-256 sum of an eight byte frame body
`timescale 1ns/1ns
module acju_csum (
  input  wire logic [63:0] frame,
  output logic      [7:0]  sum
);

  // --------------------------------------------------------------
  // byte sum
  // --------------------------------------------------------------
  // eight byte sum
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum + frame[i*8 +: 8];
    end
  end

endmodule : acju_csum

// [rtl/acju_div.sv]
// serial signed divider, quotient and remainder
`timescale 1ns/1ns
module acju_div #(
  parameter int unsigned W = 32
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic      [W-1:0] quotient,
  output logic      [W-1:0] remainder
);

  localparam int unsigned CW = $clog2(W + 1);

  logic [W-1:0]  mag_q;
  logic [W-1:0]  mag_d;
  logic [W:0]    part;
  logic [CW-1:0] count;
  logic          busy;
  logic          neg_q;
  logic          neg_r;
  logic [W:0]    trial;

  // ----------------------------------------------------------------
  // restoring shift and subtract
  // ----------------------------------------------------------------
  assign trial = {part[W-1:0], mag_q[W-1]} - {1'b0, mag_d};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mag_q <= '0;
      mag_d <= '0;
      part  <= '0;
      count <= '0;
      busy  <= 1'b0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        mag_q <= dividend[W-1] ? W'(-dividend) : dividend;
        mag_d <= divisor[W-1] ? W'(-divisor) : divisor;
        neg_q <= dividend[W-1] ^ divisor[W-1];
        neg_r <= dividend[W-1];
        part  <= '0;
        count <= CW'(W);
        busy  <= 1'b1;
      end else if (busy) begin
        if (trial[W]) begin
          part  <= {part[W-1:0], mag_q[W-1]};
          mag_q <= {mag_q[W-2:0], 1'b0};
        end else begin
          part  <= trial;
          mag_q <= {mag_q[W-2:0], 1'b1};
        end
        count <= count - CW'(1);
        if (count == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // truncation toward zero, remainder takes the dividend sign
  assign quotient  = neg_q ? W'(-mag_q) : mag_q;
  assign remainder = neg_r ? W'(-part[W-1:0]) : part[W-1:0];

endmodule : acju_div

// [testbench/acju_monitor.sv]
// bus handshake checker for the accumulator unit
`timescale 1ns/1ns
module acju_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered in two cycles");
  a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
  a_write_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer moved");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_write_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
endmodule : acju_monitor
bind acju_top acju_monitor mon_u (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [testbench/acju_host.sv]
// host model: bus master and command framing
`timescale 1ns/1ns
module acju_host
  import acju_pkg::*;
(
  input  wire logic        clock,
  output logic      [5:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [5:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  output logic             s_axi_rready
);
  logic       alone = 1'b0;
  logic [7:0] skew  = 8'h00;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ready sampled mid-cycle, so the edge that takes an item is known before it
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ta, tb;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tb);
    s_axi_rready <= 1'b0;
  endtask : rd
  // frame checksum, skew only for refusal tests
  task automatic cmd(input logic [7:0] ins, ty, bk, input logic [31:0] v);
    logic [7:0]  cs;
    logic [31:0] s;
    logic [1:0]  r;
    cs = 8'h01 + ins + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + skew;
    wr(REG_CMD, {8'h01, bk, ty, ins});
    wr(REG_VALUE, v);
    wr(REG_CSUM, {24'h0, cs});
    wr(REG_CTRL, {30'h0, alone, 1'b1});
    do rd(REG_STATUS, s, r); while (s[STAT_BUSY_BIT] !== 1'b0);
  endtask : cmd
endmodule : acju_host

// [testbench/acju_tb_top.sv]
// self-checking bench for the accumulator unit
`timescale 1ns/1ns
module acju_tb_top;
  import acju_pkg::*;
  logic        clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, wait_timeout_evt, external_alarm_in, deviation_error_in;
  logic        position_error_in, fz, fg, fl, fto;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, rnd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  digital_in;
  logic [3:0]  s_axi_wstrb = 4'hF;
  int          acc, pc, op, tg, mismatches, compares;
  integer      seed = 32'hE262;
  acju_top #(.N_IN(8)) dut_u (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .digital_in, .wait_timeout_evt, .external_alarm_in,
    .deviation_error_in, .position_error_in);
  acju_host host_u (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic conclude;
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [5:0] a, input logic [31:0] e);
    host_u.rd(a, d, r);
    cmp(d, e);
  endtask : chk
  // refused command: status code only, accumulator kept
  task automatic bad(input logic [7:0] ins, ty, st, input logic [31:0] v);
    host_u.cmd(ins, ty, BANK_DIGITAL, v);
    host_u.rd(REG_REPLY, d, r);
    cmp({24'h0, d[7:0]}, {24'h0, st});
    chk(REG_ACC, acc);
  endtask : bad
  // reply, program counter and accumulator after every command
  task automatic run(input logic [7:0] ins, ty, input logic [31:0] v, rv);
    host_u.cmd(ins, ty, BANK_DIGITAL, v);
    chk(REG_REPLY, {16'h0, 8'h67 + ins + rv[31:24] + rv[23:16] + rv[15:8] + rv[7:0], ST_OK});
    chk(REG_RVALUE, rv);
    if (host_u.alone) pc++;
    chk(REG_PC, pc);
    chk(REG_ACC, acc);
  endtask : run
  function automatic logic cond(input int t);
    case (t)
      0, 2: return fz;
      1, 3: return !fz;
      4: return fg;
      5: return !fl;
      6: return fl;
      7: return !fg;
      8: return fto;
      9: return external_alarm_in;
      10: return deviation_error_in;
      default: return position_error_in;
    endcase
  endfunction : cond
  initial begin
    rst = 1'b1;
    {wait_timeout_evt, external_alarm_in, deviation_error_in, position_error_in} = 4'h0;
    digital_in = 8'h00;
    fto = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    host_u.wr(REG_ACC, 32'h1);
    cmp({30'h0, s_axi_bresp}, {30'h0, RESP_SLVERR});
    chk(REG_ACC, ACC_RST);
    chk(REG_PC, PC_RST);
    host_u.rd(6'h24, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    cmp(d, 32'h0);
    for (int t = 0; t < 30; t++) begin
      host_u.alone = (t >= 10);
      op = $random(seed) % 1000;
      if (op == 0) op = 7;
      case (t % 10)
        0: acc += op;
        1: acc -= op;
        2: acc *= op;
        3: acc /= op;
        4: acc %= op;
        5: acc &= op;
        6: acc |= op;
        7: acc ^= op;
        8: acc = ~acc;
        default: acc = op;
      endcase
      run(OP_ACC, 8'(t % 10), op, op);
    end
    rnd = $random(seed);
    digital_in <= rnd[7:0];
    @(posedge clock);
    acc = {24'h0, rnd[7:0]};
    run(OP_READ_INPUT, PORT_ALL, 32'h0, {24'h0, rnd[7:0]});
    host_u.alone = 1'b0;
    for (int p = 0; p < 8; p++)
      run(OP_READ_INPUT, 8'(p), 32'h0, {31'h0, rnd[p]});
    host_u.alone = 1'b1;
    for (int k = 0; k < 36; k++) begin
      rnd = $random(seed);
      {external_alarm_in, deviation_error_in, position_error_in} <= rnd[4:2];
      wait_timeout_evt <= rnd[5];
      @(posedge clock);
      wait_timeout_evt <= 1'b0;
      fto = rnd[5];
      if (!rnd[5]) host_u.wr(REG_CTRL, 32'h6);
      op = acc + int'($signed(rnd[1:0]));
      run(OP_COMPARE, 8'h0, op, 32'h0);
      fz = acc == op;
      fg = acc > op;
      fl = acc < op;
      chk(REG_STATUS, {23'h0, position_error_in, deviation_error_in, external_alarm_in,
        fto, fl, fg, fz, fz, 1'b0});
      tg = rnd[15:8];
      if (cond(k % 12)) pc = tg - 1;
      run(OP_JUMP, 8'(k % 12), tg, 32'h0);
    end
    host_u.skew = 8'h01;
    bad(OP_ACC, ACCUMULATOR_OP_CMD_ADD, ST_BAD_CSUM, 32'h5);
    host_u.skew = 8'h00;
    bad(OP_ACC, 8'h0A, ST_BAD_TYPE, 32'h0);
    bad(OP_ACC, ACCUMULATOR_OP_CMD_DIV, ST_BAD_VAL, 32'h0);
    bad(8'h7F, 8'h00, ST_BAD_CMD, 32'h0);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule : acju_tb_top
